// ### rtl/sink_select_pkg.sv
package sink_select_pkg;

    // Clock rate and timing figures
    localparam int CLK_HZ = 50_000_000;
    localparam int D3_WAKE_MAX_US = 50;
    localparam int D3_WAKE_MAX_CYC = (D3_WAKE_MAX_US * (CLK_HZ / 1_000_000));
    localparam int PLUG_LOW_MIN_US = 2;
    localparam int PLUG_LOW_MIN_CYC = PLUG_LOW_MIN_US * (CLK_HZ / 1_000_000);
    localparam int D3_WAKE_SETTLE_CYC = 64;
    localparam int CNT_W = 16;

    // Local control port rate limit
    localparam int I2C_MAX_KBPS = 100;
    localparam int I2C_MIN_CLK_PER_BIT = 16;

    // Output swing and input equalizer settings
    localparam int TMDS_SWING_DEF_MV = 600;
    localparam logic [9:0] TMDS_SWING_DEF = 10'h258;
    localparam logic [1:0] LVL_RESET = 2'h0;
    localparam logic [3:0] EQ_RESET = 4'h0;

    // Operating modes
    typedef enum {
        MODE_SHUTDOWN,
        MODE_STANDBY,
        MODE_DP_ACTIVE,
        MODE_HDMI_ACTIVE,
        MODE_D3
    } mode_t;

    // Snooped side-channel transaction kinds
    typedef enum logic [1:0] {
        AUX_OTHER = 2'h0,
        AUX_TRAIN = 2'h1,
        AUX_D3_ENTER = 2'h2,
        AUX_D3_EXIT = 2'h3
    } aux_kind_t;

    typedef struct packed {
        logic valid;
        aux_kind_t kind;
        logic [1:0] swing;
        logic [1:0] preemph;
    } aux_txn_t;

    // Settings held by the local control port
    typedef struct packed {
        logic train_off;
        logic [1:0] swing;
        logic [1:0] preemph;
        logic eq_set;
        logic [3:0] eq;
        logic tmds_swing_set;
        logic [9:0] tmds_swing_mv;
    } local_cfg_t;

    typedef struct packed {
        logic [1:0] swing;
        logic [1:0] preemph;
        logic [3:0] eq;
        logic [9:0] tmds_swing_mv;
    } conditioning_t;

endpackage

// ### rtl/sink_select_mode_control.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1: Chip enable low: shutdown, all defaults
// RULE2: Shutdown: source plug follows either sink
// RULE3: Shutdown: other outputs released, inputs ignored
// RULE4: Standby on no sink or preference swap
// RULE5: Standby drives plug, cable detect low
// RULE6: Preference sink change passes through standby
// RULE7: Enter DP mode; tolerate short plug drops
// RULE8: Both plugged, preference low picks DP
// RULE9: DP mode: cable detect picks TMDS
// RULE10: TMDS: DDC routed, cable detect high
// RULE11: TMDS swing 600 mVpp unless overridden
// RULE12: DP signalling: AUX routed, cable detect low
// RULE13: Training snoop enables link, overridable locally
// RULE14: Monitor ignores non-training, non-D3 transactions
// RULE15: Conditioning from training, inputs, local settings
// RULE16: D3 wake brings link up within 50us
// RULE17: Local port standard mode, 100 kbps
// RULE18: Enter-D3 command disables link, port active
// RULE19: Both plugged, preference high picks HDMI
// RULE20: Squelch disables outputs until signal returns
// RULE21: System raises enable after supplies stable
// RULE22: Minimum plug low time is a parameter
module sink_select_mode_control #(
    parameter int PLUG_LOW_MIN_CYC = sink_select_pkg::PLUG_LOW_MIN_CYC,
    parameter int D3_WAKE_SETTLE_CYC = sink_select_pkg::D3_WAKE_SETTLE_CYC,
    parameter int I2C_CLK_PER_BIT = sink_select_pkg::CLK_HZ
        / (sink_select_pkg::I2C_MAX_KBPS * 1000)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Device enable, also the logic reset
    input wire logic chip_enable,
    // Sink side presence
    input wire logic dp_sink_plug_in,
    input wire logic tmds_sink_plug_in,
    input wire logic sink_cable_detect_in,
    input wire logic sink_pref_in,
    // Main link input level and equalizer control
    input wire logic squelch_in,
    input wire logic [3:0] eq_ctl_in,
    // Snooped side-channel transactions
    input wire sink_select_pkg::aux_txn_t aux_txn_in,
    // Local control port settings
    input wire sink_select_pkg::local_cfg_t local_cfg_in,
    // Source side detect outputs
    output logic source_plug_out,
    output logic source_plug_oe,
    output logic source_cable_detect_out,
    output logic source_cable_detect_oe,
    // Switch and link controls
    output logic main_link_en,
    output logic ddc_route_en,
    output logic aux_route_en,
    output logic local_port_en,
    output logic aux_monitor_en,
    output logic dp_sink_sel,
    output logic hdmi_sink_sel,
    output logic d3_active,
    output sink_select_pkg::conditioning_t conditioning_out
);

    // Settings that the logic cannot serve are refused at elaboration
    // A zero count would wrap the last count to 16'hFFFF, giving the longest standby hold and drop filter
    if (PLUG_LOW_MIN_CYC < 1
        || PLUG_LOW_MIN_CYC >= (1 << sink_select_pkg::CNT_W)) begin : g_plug_chk
        $error("plug low count out of range");
    end
    // The settle count is the whole wake latency, so it must fit the bound
    if (D3_WAKE_SETTLE_CYC < 1
        || D3_WAKE_SETTLE_CYC > sink_select_pkg::D3_WAKE_MAX_CYC) begin : g_wake_chk
        $error("D3 wake settle exceeds bound");
    end
    if (I2C_CLK_PER_BIT < sink_select_pkg::I2C_MIN_CLK_PER_BIT) begin : g_rate_chk
        $error("clock too slow for local port rate");
    end

    localparam logic [15:0] PLUG_LOW_LAST = 16'(PLUG_LOW_MIN_CYC - 1);
    localparam logic [15:0] WAKE_LAST = 16'(D3_WAKE_SETTLE_CYC - 1);

    sink_select_pkg::mode_t mode_q;
    sink_select_pkg::mode_t mode_d;
    logic [15:0] low_cnt_q;
    logic [15:0] wake_cnt_q;
    logic waking_q;
    logic trained_q;
    logic dp_drop_long;
    logic standby_done;
    logic want_dp;
    logic want_hdmi;
    logic dp_signalling;
    logic enabled;
    logic train_hit;
    logic d3_enter_hit;
    logic d3_exit_hit;

    // Reset and chip enable both force the default state
    assign enabled = rst_n && chip_enable; // RULE1 RULE21

    // Sink choice, with the preference only deciding a tie
    always_comb begin
        want_dp = dp_sink_plug_in && !(tmds_sink_plug_in && sink_pref_in); // RULE8
        want_hdmi = tmds_sink_plug_in && !(dp_sink_plug_in && !sink_pref_in); // RULE19
    end

    assign dp_signalling = !sink_cable_detect_in; // RULE9

    // Only training and D3 commands are acted on
    always_comb begin
        train_hit = aux_txn_in.valid && aux_txn_in.kind == sink_select_pkg::AUX_TRAIN; // RULE14
        d3_enter_hit = aux_txn_in.valid && aux_txn_in.kind == sink_select_pkg::AUX_D3_ENTER;
        d3_exit_hit = aux_txn_in.valid && aux_txn_in.kind == sink_select_pkg::AUX_D3_EXIT;
    end

    // A drop counts only once it outlasts the minimum low time
    assign dp_drop_long = !dp_sink_plug_in && low_cnt_q >= PLUG_LOW_LAST; // RULE7 RULE22
    assign standby_done = low_cnt_q >= PLUG_LOW_LAST; // RULE5

    // Mode sequencing
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            sink_select_pkg::MODE_SHUTDOWN: begin
                mode_d = sink_select_pkg::MODE_STANDBY;
            end
            sink_select_pkg::MODE_STANDBY: begin
                // Hold here for the full low time before any sink is shown
                if (standby_done && want_dp) begin
                    mode_d = sink_select_pkg::MODE_DP_ACTIVE; // RULE7
                end else if (standby_done && want_hdmi) begin
                    mode_d = sink_select_pkg::MODE_HDMI_ACTIVE;
                end
            end
            sink_select_pkg::MODE_DP_ACTIVE: begin
                if (dp_drop_long) begin
                    mode_d = sink_select_pkg::MODE_STANDBY; // RULE4
                end else if (dp_sink_plug_in && want_hdmi) begin
                    mode_d = sink_select_pkg::MODE_STANDBY; // RULE6
                end else if (dp_signalling && d3_enter_hit) begin
                    mode_d = sink_select_pkg::MODE_D3; // RULE18
                end
            end
            sink_select_pkg::MODE_HDMI_ACTIVE: begin
                if (!tmds_sink_plug_in || want_dp) begin
                    mode_d = sink_select_pkg::MODE_STANDBY; // RULE4 RULE6
                end
            end
            sink_select_pkg::MODE_D3: begin
                if (dp_drop_long || (dp_sink_plug_in && want_hdmi)) begin
                    mode_d = sink_select_pkg::MODE_STANDBY;
                end else if (waking_q && wake_cnt_q >= WAKE_LAST) begin
                    mode_d = sink_select_pkg::MODE_DP_ACTIVE; // RULE16
                end
            end
            default: begin
                mode_d = sink_select_pkg::MODE_STANDBY;
            end
        endcase
    end

    // Mode register
    always_ff @(posedge clk) begin
        if (!enabled) begin
            mode_q <= sink_select_pkg::MODE_SHUTDOWN; // RULE1
        end else begin
            mode_q <= mode_d;
        end
    end

    // One counter serves both the standby hold and the drop filter
    always_ff @(posedge clk) begin
        if (!enabled) begin
            low_cnt_q <= 16'h0000;
        end else if (mode_q != mode_d) begin
            low_cnt_q <= 16'h0000;
        end else if (mode_q == sink_select_pkg::MODE_STANDBY) begin
            if (!standby_done) begin
                low_cnt_q <= low_cnt_q + 16'h0001; // RULE5
            end
        end else if (dp_sink_plug_in) begin
            low_cnt_q <= 16'h0000;
        end else if (!dp_drop_long) begin
            low_cnt_q <= low_cnt_q + 16'h0001; // RULE7
        end
    end

    // D3 wake timer, started by the exit command
    always_ff @(posedge clk) begin
        if (!enabled || mode_q != sink_select_pkg::MODE_D3) begin
            waking_q <= 1'b0;
            wake_cnt_q <= 16'h0000;
        end else if (d3_exit_hit) begin
            waking_q <= 1'b1; // RULE16
        end else if (waking_q) begin
            wake_cnt_q <= wake_cnt_q + 16'h0001;
        end
    end

    // Link training result; the local port may switch snooping off
    always_ff @(posedge clk) begin
        if (!enabled) begin
            trained_q <= 1'b0;
        end else if (mode_q == sink_select_pkg::MODE_STANDBY) begin
            trained_q <= 1'b0;
        end else if (local_cfg_in.train_off) begin
            trained_q <= 1'b1; // RULE13
        end else if (mode_q == sink_select_pkg::MODE_DP_ACTIVE && dp_signalling && train_hit) begin
            trained_q <= 1'b1; // RULE13
        end
    end

    // Source plug pin; the only output still driven in shutdown
    always_ff @(posedge clk) begin
        if (!enabled) begin
            source_plug_out <= dp_sink_plug_in || tmds_sink_plug_in; // RULE2
        end else begin
            case (mode_d)
                sink_select_pkg::MODE_STANDBY,
                sink_select_pkg::MODE_SHUTDOWN: begin
                    source_plug_out <= 1'b0; // RULE5
                end
                sink_select_pkg::MODE_DP_ACTIVE,
                sink_select_pkg::MODE_D3: begin
                    // Short drops are passed on so the source sees the sink request
                    source_plug_out <= dp_sink_plug_in; // RULE7
                end
                default: begin
                    source_plug_out <= tmds_sink_plug_in;
                end
            endcase
        end
    end

    // Plug pin is driven in every mode, shutdown included
    always_ff @(posedge clk) begin
        source_plug_oe <= 1'b1; // RULE2
    end

    // Cable detect pin; released in shutdown
    always_ff @(posedge clk) begin
        if (!enabled) begin
            source_cable_detect_out <= 1'b0;
            source_cable_detect_oe <= 1'b0; // RULE3
        end else begin
            source_cable_detect_oe <= 1'b1;
            case (mode_d)
                sink_select_pkg::MODE_DP_ACTIVE,
                sink_select_pkg::MODE_D3: begin
                    source_cable_detect_out <= !dp_signalling; // RULE10 RULE12
                end
                default: begin
                    // Standby shows no sink; HDMI mode leaves it low
                    source_cable_detect_out <= 1'b0; // RULE5
                end
            endcase
        end
    end

    // Sink selection and power state flags
    always_ff @(posedge clk) begin
        if (!enabled) begin
            dp_sink_sel <= 1'b0;
            hdmi_sink_sel <= 1'b0;
            d3_active <= 1'b0;
        end else begin
            dp_sink_sel <= mode_d == sink_select_pkg::MODE_DP_ACTIVE
                || mode_d == sink_select_pkg::MODE_D3;
            hdmi_sink_sel <= mode_d == sink_select_pkg::MODE_HDMI_ACTIVE;
            d3_active <= mode_d == sink_select_pkg::MODE_D3; // RULE18
        end
    end

    // Side-channel switches and port enables
    always_ff @(posedge clk) begin
        if (!enabled) begin
            ddc_route_en <= 1'b0; // RULE3
            aux_route_en <= 1'b0;
            local_port_en <= 1'b0; // RULE1
            aux_monitor_en <= 1'b0;
        end else begin
            local_port_en <= 1'b1; // RULE4 RULE17
            ddc_route_en <= mode_d == sink_select_pkg::MODE_DP_ACTIVE
                && !dp_signalling; // RULE10
            aux_route_en <= (mode_d == sink_select_pkg::MODE_DP_ACTIVE
                || mode_d == sink_select_pkg::MODE_D3) && dp_signalling; // RULE12
            aux_monitor_en <= (mode_d == sink_select_pkg::MODE_DP_ACTIVE
                || mode_d == sink_select_pkg::MODE_D3) && dp_signalling; // RULE13 RULE18
        end
    end

    // Main link enable; squelch gates it without leaving the mode
    always_ff @(posedge clk) begin
        if (!enabled) begin
            main_link_en <= 1'b0; // RULE1
        end else if (squelch_in) begin
            main_link_en <= 1'b0; // RULE20
        end else begin
            case (mode_d)
                sink_select_pkg::MODE_DP_ACTIVE: begin
                    // TMDS signalling needs no training
                    main_link_en <= !dp_signalling || trained_q; // RULE13
                end
                sink_select_pkg::MODE_HDMI_ACTIVE: begin
                    main_link_en <= 1'b1;
                end
                default: begin
                    main_link_en <= 1'b0; // RULE4 RULE18
                end
            endcase
        end
    end

    // Output conditioning and input equalizer
    always_ff @(posedge clk) begin
        if (!enabled) begin
            conditioning_out.swing <= sink_select_pkg::LVL_RESET;
            conditioning_out.preemph <= sink_select_pkg::LVL_RESET;
            conditioning_out.eq <= sink_select_pkg::EQ_RESET;
            conditioning_out.tmds_swing_mv <= sink_select_pkg::TMDS_SWING_DEF;
        end else begin
            // Local setting wins over the control pins
            conditioning_out.eq <= local_cfg_in.eq_set ? local_cfg_in.eq : eq_ctl_in; // RULE15
            conditioning_out.tmds_swing_mv <= local_cfg_in.tmds_swing_set
                ? local_cfg_in.tmds_swing_mv : sink_select_pkg::TMDS_SWING_DEF; // RULE11
            if (local_cfg_in.train_off) begin
                conditioning_out.swing <= local_cfg_in.swing; // RULE13 RULE15
                conditioning_out.preemph <= local_cfg_in.preemph;
            end else if (mode_q == sink_select_pkg::MODE_DP_ACTIVE && dp_signalling
                && train_hit) begin
                conditioning_out.swing <= aux_txn_in.swing; // RULE15
                conditioning_out.preemph <= aux_txn_in.preemph;
            end
        end
    end

endmodule

`default_nettype wire

// ### sim/sink_select_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sink_select_sva #(
    parameter int PLUG_LOW_MIN_CYC = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chip_enable,
    // Sink side and controls
    input wire logic dp_sink_plug_in,
    input wire logic tmds_sink_plug_in,
    input wire logic sink_cable_detect_in,
    input wire logic squelch_in,
    input wire logic [3:0] eq_ctl_in,
    input wire sink_select_pkg::aux_txn_t aux_txn_in,
    input wire sink_select_pkg::local_cfg_t local_cfg_in,
    // Design outputs
    input wire logic source_plug_out,
    input wire logic source_plug_oe,
    input wire logic source_cable_detect_out,
    input wire logic source_cable_detect_oe,
    input wire logic main_link_en,
    input wire logic ddc_route_en,
    input wire logic aux_route_en,
    input wire logic local_port_en,
    input wire logic aux_monitor_en,
    input wire logic dp_sink_sel,
    input wire logic hdmi_sink_sel,
    input wire logic d3_active,
    input wire sink_select_pkg::conditioning_t conditioning_out
);
    localparam int WAKE_MAX = sink_select_pkg::D3_WAKE_MAX_CYC;
    logic stby;
    logic [15:0] stby_cnt_q;
    logic [15:0] wake_cnt_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Standby seen at the pins: driven detect, no sink selected
    assign stby = chip_enable && source_cable_detect_oe && !dp_sink_sel && !hdmi_sink_sel;

    // Length of the current standby stretch, for the plug low bound
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stby_cnt_q <= 16'h0000;
        end else begin
            // Saturates so a long stay without a sink cannot wrap
            stby_cnt_q <= stby ? stby_cnt_q + 16'(stby_cnt_q != 16'hFFFF) : 16'h0000;
        end
    end

    // Cycles since the exit command while D3 still holds; zero when idle
    always_ff @(posedge clk) begin
        if (!rst_n || !d3_active) begin
            wake_cnt_q <= 16'h0000;
        end else if (wake_cnt_q != 16'h0000 || (aux_txn_in.valid
            && aux_txn_in.kind == sink_select_pkg::AUX_D3_EXIT)) begin
            wake_cnt_q <= wake_cnt_q + 16'h0001;
        end
    end

    property p_shdn_plug;
        !chip_enable |=> source_plug_oe
            && source_plug_out == $past(dp_sink_plug_in | tmds_sink_plug_in);
    endproperty
    a_shdn_plug: assert property (p_shdn_plug) else $error("shutdown plug wrong");
    property p_shdn_off;
        !chip_enable |=> !source_cable_detect_oe && !main_link_en && !local_port_en
            && !aux_route_en && !ddc_route_en && !d3_active;
    endproperty
    a_shdn_off: assert property (p_shdn_off) else $error("shutdown output on");
    property p_stby_low;
        stby |-> !source_plug_out && !source_cable_detect_out && local_port_en && !main_link_en;
    endproperty
    a_stby_low: assert property (p_stby_low) else $error("standby levels wrong");
    property p_stby_len;
        $rose(dp_sink_sel || hdmi_sink_sel) && !$past(d3_active)
            |-> stby_cnt_q >= PLUG_LOW_MIN_CYC - 1;
    endproperty
    a_stby_len: assert property (p_stby_len) else $error("standby too short");
    property p_swap;
        $fell(dp_sink_sel) || $fell(hdmi_sink_sel) |-> !dp_sink_sel && !hdmi_sink_sel;
    endproperty
    a_swap: assert property (p_swap) else $error("sink swap skipped standby");
    property p_sub;
        dp_sink_sel && $past(dp_sink_sel) && !d3_active && $stable(sink_cable_detect_in)
            |-> source_cable_detect_out == sink_cable_detect_in
            && ddc_route_en == sink_cable_detect_in && aux_route_en == !sink_cable_detect_in;
    endproperty
    a_sub: assert property (p_sub) else $error("sub-mode routing wrong");
    property p_train;
        aux_txn_in.valid && aux_txn_in.kind == sink_select_pkg::AUX_TRAIN && dp_sink_sel
            && !d3_active && !sink_cable_detect_in && !squelch_in && !local_cfg_in.train_off
            |-> ##2 main_link_en && conditioning_out.swing == $past(aux_txn_in.swing, 2);
    endproperty
    a_train: assert property (p_train) else $error("training not applied");
    property p_other;
        aux_txn_in.valid && aux_txn_in.kind == sink_select_pkg::AUX_OTHER && dp_sink_sel
            && !main_link_en && !d3_active && !sink_cable_detect_in && !local_cfg_in.train_off
            |-> ##2 !main_link_en && !d3_active;
    endproperty
    a_other: assert property (p_other) else $error("other transaction acted on");
    property p_d3;
        aux_txn_in.valid && aux_txn_in.kind == sink_select_pkg::AUX_D3_ENTER && dp_sink_sel
            && !sink_cable_detect_in && !d3_active
            |=> d3_active && !main_link_en && local_port_en && aux_monitor_en;
    endproperty
    a_d3: assert property (p_d3) else $error("enter D3 wrong");
    property p_wake;
        d3_active && wake_cnt_q != 16'h0000 |-> wake_cnt_q <= WAKE_MAX;
    endproperty
    a_wake: assert property (p_wake) else $error("D3 wake too slow");
    property p_squelch;
        squelch_in && chip_enable |=> !main_link_en;
    endproperty
    a_squelch: assert property (p_squelch) else $error("squelch ignored");
    property p_cond;
        chip_enable |=> conditioning_out.eq
            == $past(local_cfg_in.eq_set ? local_cfg_in.eq : eq_ctl_in)
            && conditioning_out.tmds_swing_mv == $past(local_cfg_in.tmds_swing_set
            ? local_cfg_in.tmds_swing_mv : sink_select_pkg::TMDS_SWING_DEF);
    endproperty
    a_cond: assert property (p_cond) else $error("conditioning wrong");
endmodule
bind sink_select_mode_control sink_select_sva #(.PLUG_LOW_MIN_CYC(PLUG_LOW_MIN_CYC)) u_sva (.*);
`default_nettype wire

// ### sim/sink_model.sv
`timescale 1ns/1ps
`default_nettype none
module sink_model (
    // Clock
    input wire logic clk,
    // Sink presence and snooped side channel
    output var logic dp_sink_plug_in,
    output var logic tmds_sink_plug_in,
    output var logic sink_cable_detect_in,
    output var sink_select_pkg::aux_txn_t aux_txn_in
);
    // Nothing plugged at power up
    initial begin
        dp_sink_plug_in = 1'b0;
        tmds_sink_plug_in = 1'b0;
        sink_cable_detect_in = 1'b0;
        aux_txn_in = '0;
    end

    task automatic plug(input logic dp, input logic tm, input logic cab);
        dp_sink_plug_in = dp;
        tmds_sink_plug_in = tm;
        sink_cable_detect_in = cab;
    endtask

    // One-cycle transaction; idle fields inverted so stale data never looks valid
    task automatic send(input sink_select_pkg::aux_kind_t k, input logic [1:0] sw,
                        input logic [1:0] pe);
        aux_txn_in = '{valid: 1'b1, kind: k, swing: sw, preemph: pe};
        @(negedge clk);
        aux_txn_in = '{valid: 1'b0, kind: sink_select_pkg::aux_kind_t'(~k), swing: ~sw,
                       preemph: ~pe};
    endtask

    // Interrupt request: short plug drop
    task automatic blip(input int n);
        dp_sink_plug_in = 1'b0;
        repeat (n) @(negedge clk);
        dp_sink_plug_in = 1'b1;
    endtask
endmodule
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int PLUG = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic chip_enable = 1'b0;
    logic sink_pref_in = 1'b0;
    logic squelch_in = 1'b0;
    logic [3:0] eq_ctl_in = 4'h0;
    sink_select_pkg::local_cfg_t local_cfg_in = '0;
    logic dp_sink_plug_in, tmds_sink_plug_in, sink_cable_detect_in;
    sink_select_pkg::aux_txn_t aux_txn_in;
    logic source_plug_out, source_plug_oe, source_cable_detect_out, source_cable_detect_oe;
    logic main_link_en, ddc_route_en, aux_route_en, local_port_en, aux_monitor_en;
    logic dp_sink_sel, hdmi_sink_sel, d3_active;
    sink_select_pkg::conditioning_t conditioning_out;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    int n;

    always #10 clk = ~clk;

    sink_model u_sink (.*);
    sink_select_mode_control #(.PLUG_LOW_MIN_CYC(PLUG), .D3_WAKE_SETTLE_CYC(4)) u_dut (.*);

    task automatic step(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Hang guard, far above the fewer than a hundred cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        step(3);
        rst_n = 1'b1;
        u_sink.plug(1'b1, 1'b0, 1'b0);
        step(2);
        chk(source_plug_out, 1'b1);
        chk(source_cable_detect_oe, 1'b0);
        chk({main_link_en, local_port_en, aux_route_en, ddc_route_en}, 4'h0);
        chk(conditioning_out.tmds_swing_mv, 10'h258);
        u_sink.plug(1'b0, 1'b1, 1'b0);
        step(2);
        chk(source_plug_out, 1'b1);
        u_sink.plug(1'b1, 1'b0, 1'b0);
        chip_enable = 1'b1;
        step(2);
        chk({source_plug_out, source_cable_detect_oe, source_cable_detect_out}, 3'h2);
        chk({local_port_en, main_link_en}, 2'h2);
        step(PLUG + 2);
        chk({dp_sink_sel, source_plug_out, aux_route_en, source_cable_detect_out}, 4'hE);
        $display("test enable done");
        u_sink.send(sink_select_pkg::AUX_OTHER, 2'h2, 2'h1);
        step(2);
        chk(main_link_en, 1'b0);
        eq_ctl_in = 4'hA;
        u_sink.send(sink_select_pkg::AUX_TRAIN, 2'h2, 2'h1);
        step(1);
        chk(main_link_en, 1'b1);
        chk(conditioning_out[17:10], 8'h9A);
        squelch_in = 1'b1;
        step(1);
        chk(main_link_en, 1'b0);
        squelch_in = 1'b0;
        step(2);
        chk(main_link_en, 1'b1);
        u_sink.blip(PLUG - 2);
        step(1);
        chk(dp_sink_sel, 1'b1);
        $display("test training done");
        u_sink.send(sink_select_pkg::AUX_D3_ENTER, 2'h0, 2'h0);
        chk({d3_active, main_link_en, local_port_en, aux_monitor_en}, 4'hB);
        step(1);
        u_sink.send(sink_select_pkg::AUX_D3_EXIT, 2'h0, 2'h0);
        for (n = 0; n < 2500 && main_link_en !== 1'b1; n++) step(1);
        chk({d3_active, main_link_en}, 2'h1);
        $display("test d3 done");
        u_sink.plug(1'b1, 1'b0, 1'b1);
        step(2);
        chk({source_cable_detect_out, ddc_route_en, aux_route_en}, 3'h6);
        chk({main_link_en, conditioning_out.tmds_swing_mv}, 11'h658);
        local_cfg_in.tmds_swing_set = 1'b1;
        local_cfg_in.tmds_swing_mv = 10'h1F4;
        local_cfg_in.eq_set = 1'b1;
        local_cfg_in.eq = 4'h3;
        step(2);
        chk({conditioning_out.eq, conditioning_out.tmds_swing_mv}, 14'h0DF4);
        u_sink.plug(1'b1, 1'b0, 1'b0);
        local_cfg_in.train_off = 1'b1;
        local_cfg_in.swing = 2'h3;
        step(2);
        chk({conditioning_out.swing, aux_route_en}, 3'h7);
        $display("test tmds done");
        u_sink.plug(1'b1, 1'b1, 1'b0);
        sink_pref_in = 1'b1;
        step(2);
        chk({dp_sink_sel, hdmi_sink_sel, source_plug_out}, 3'h0);
        step(PLUG + 2);
        chk({hdmi_sink_sel, source_plug_out}, 2'h3);
        sink_pref_in = 1'b0;
        step(2);
        chk({dp_sink_sel, hdmi_sink_sel}, 2'h0);
        step(PLUG + 3);
        chk({dp_sink_sel, hdmi_sink_sel}, 2'h2);
        u_sink.plug(1'b0, 1'b0, 1'b0);
        step(PLUG + 3);
        chk({dp_sink_sel, source_plug_out, source_cable_detect_out}, 3'h0);
        $display("test select done");
        chip_enable = 1'b0;
        step(2);
        chk({local_port_en, source_cable_detect_oe}, 2'h0);
        $display("test shutdown done");
        conclude();
    end
endmodule
`default_nettype wire
